// *** design/pdcs_defines.svh ***
`ifndef PDCS_DEFINES_SVH
`define PDCS_DEFINES_SVH
`define PDCS_MODE_SHUT   2'h0
`define PDCS_MODE_MANUAL 2'h1
`define PDCS_MODE_SEMI   2'h2
`define PDCS_MODE_AUTO   2'h3
`define PDCS_RES_LO_K    8'h11
`define PDCS_RES_HI_K    8'h1d
`define PDCS_RES_OPEN_K  8'h32
`define PDCS_SHORT_MV    16'h03e8
`define PDCS_OVER_MV     16'h2710
`define PDCS_CAP_HI_NF   16'h0a8c
`define PDCS_CAP_LEG_NF  16'h2710
`define PDCS_WAIT_MS     100
`define PDCS_CLK_HZ      20000000
`define PDCS_WAIT_CYC    ((`PDCS_WAIT_MS * (`PDCS_CLK_HZ / 1000)))
`define PDCS_CLASS0      3'h0
`define PDCS_CLASS3      3'h3
`endif

// *** design/pdcs_pkg.sv ***
package pdcs_pkg;
   typedef enum logic [3:0] {
      PDCS_DET_UNKNOWN, PDCS_DET_SHORT, PDCS_DET_CAP_HIGH, PDCS_DET_R_LOW,
      PDCS_DET_GOOD, PDCS_DET_R_HIGH, PDCS_DET_OPEN, PDCS_DET_VOLT_OUT,
      PDCS_DET_CC_INVALID, PDCS_DET_REFER
   } pdcs_det_t;
   typedef struct packed {
      logic [7:0]  res_k;
      logic [15:0] volt_mv;
      logic [15:0] cap_nf;
   } pdcs_meas_t;
   typedef struct packed {
      logic [7:0] icut;
      logic [7:0] ilim;
      logic [7:0] pcut;
   } pdcs_thr_t;
endpackage : pdcs_pkg

// *** design/pdcs_judge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_defines.svh"
module pdcs_judge
(
   input  wire pdcs_pkg::pdcs_meas_t meas,
   input  wire logic                 legacy_en,
   output pdcs_pkg::pdcs_det_t       verdict
);
   always_comb
   begin
      if (meas.volt_mv < `PDCS_SHORT_MV)
         verdict = pdcs_pkg::PDCS_DET_SHORT;
      else if (meas.volt_mv > `PDCS_OVER_MV)
         verdict = pdcs_pkg::PDCS_DET_VOLT_OUT;
      else if (legacy_en && meas.cap_nf > `PDCS_CAP_LEG_NF)
         verdict = pdcs_pkg::PDCS_DET_GOOD;
      else if (meas.cap_nf > `PDCS_CAP_HI_NF)
         verdict = pdcs_pkg::PDCS_DET_CAP_HIGH;
      else if (meas.res_k < `PDCS_RES_LO_K)
         verdict = pdcs_pkg::PDCS_DET_R_LOW;
      else if (meas.res_k > `PDCS_RES_OPEN_K)
         verdict = pdcs_pkg::PDCS_DET_OPEN;
      else if (meas.res_k > `PDCS_RES_HI_K)
         verdict = pdcs_pkg::PDCS_DET_R_HIGH;
      else
         verdict = pdcs_pkg::PDCS_DET_GOOD;
   end
endmodule : pdcs_judge
`default_nettype wire

// *** design/pdcs_thr_lut.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_defines.svh"
module pdcs_thr_lut
(
   input  wire logic [2:0]     pd_class,
   output pdcs_pkg::pdcs_thr_t thr
);
   logic [2:0] eff;
   always_comb
   begin
      eff = (pd_class == `PDCS_CLASS0) ? `PDCS_CLASS3 : pd_class;
      unique case (eff)
         3'h1:    thr = '{icut: 8'h5e, ilim: 8'h6a, pcut: 8'h36};
         3'h2:    thr = '{icut: 8'h96, ilim: 8'h6a, pcut: 8'h57};
         3'h3:    thr = '{icut: 8'h54, ilim: 8'h6a, pcut: 8'hc3};
         3'h4:    thr = '{icut: 8'h9f, ilim: 8'hd4, pcut: 8'hb6};
         3'h5:    thr = '{icut: 8'h91, ilim: 8'hd4, pcut: 8'h83};
         3'h6:    thr = '{icut: 8'hb6, ilim: 8'hd4, pcut: 8'haf};
         3'h7:    thr = '{icut: 8'hce, ilim: 8'hff, pcut: 8'hda};
         default: thr = '{icut: 8'hf3, ilim: 8'hff, pcut: 8'hf1};
      endcase
   end
endmodule : pdcs_thr_lut
`default_nettype wire

// *** design/pdcs_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdcs_defines.svh"
module pdcs_seq
#(
   parameter int unsigned WAIT_CYC = `PDCS_WAIT_CYC
)
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 auto_strap,
   input  wire logic                 reset_all,
   input  wire logic [1:0]           port_op_mode_field,
   input  wire logic                 detect_en,
   input  wire logic                 class_en,
   input  wire logic                 legacy_en,
   input  wire logic                 force_class,
   input  wire logic                 force_power,
   input  wire logic                 detect_cmd,
   input  wire logic                 power_on_cmd,
   input  wire logic                 power_off_cmd,
   input  wire logic                 meas_valid,
   input  wire pdcs_pkg::pdcs_meas_t meas_a,
   input  wire pdcs_pkg::pdcs_meas_t meas_b,
   input  wire logic                 conn_single,
   input  wire logic                 conn_invalid,
   input  wire logic [2:0]           class_meas,
   input  wire logic                 thr_wr,
   input  wire pdcs_pkg::pdcs_thr_t  thr_wdata,
   output logic                      force_current,
   output logic                      force_voltage,
   output logic                      probe_second,
   output logic                      classification_voltage,
   output logic                      port_output_pin,
   output logic                      startup_fault,
   output logic                      cycle_done,
   output pdcs_pkg::pdcs_det_t       port_det,
   output pdcs_pkg::pdcs_det_t       chan_a_det,
   output pdcs_pkg::pdcs_det_t       chan_b_det,
   output logic [2:0]                port_class,
   output pdcs_pkg::pdcs_thr_t       thr
);
   typedef enum logic [2:0] {S_IDLE, S_CURR, S_VOLT, S_CLASS, S_WAIT} pdcs_state_t;
   pdcs_state_t         state_q;
   logic                step_q;
   logic                strap_q;
   logic                strap_taken_q;
   logic [31:0]         wait_q;
   pdcs_pkg::pdcs_det_t va;
   pdcs_pkg::pdcs_det_t vb;
   pdcs_pkg::pdcs_thr_t lut_thr;
   logic                shut;
   logic                det_ok;
   logic                cls_ok;
   logic                both_good;
   logic                auto_mode;
   logic                poll_mode;

   pdcs_judge u_judge_a (.meas(meas_a), .legacy_en(legacy_en), .verdict(va));
   pdcs_judge u_judge_b (.meas(meas_b), .legacy_en(legacy_en), .verdict(vb));
   pdcs_thr_lut u_lut (.pd_class(class_meas), .thr(lut_thr));

   // The strap is caught by a clocked process after release, never by the reset itself.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         strap_q       <= 1'b0;
         strap_taken_q <= 1'b0;
      end
      else if (reset_all)
      begin
         strap_taken_q <= 1'b0;
      end
      else if (!strap_taken_q)
      begin
         strap_q       <= auto_strap;
         strap_taken_q <= 1'b1;
      end
   end

   assign shut      = (port_op_mode_field == `PDCS_MODE_SHUT);
   assign auto_mode = (port_op_mode_field == `PDCS_MODE_AUTO);
   assign poll_mode = auto_mode || (port_op_mode_field == `PDCS_MODE_SEMI);
   // A low strap only leaves the enables to the host; a high strap enables by itself.
   assign det_ok    = strap_taken_q && !shut && (detect_en || strap_q);
   assign cls_ok    = strap_taken_q && !shut && (class_en || strap_q);
   assign both_good = (va == pdcs_pkg::PDCS_DET_GOOD) && (vb == pdcs_pkg::PDCS_DET_GOOD);

   assign force_current          = (state_q == S_CURR);
   assign force_voltage          = (state_q == S_VOLT);
   assign classification_voltage = (state_q == S_CLASS);
   assign probe_second           = step_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= S_IDLE;
         step_q  <= 1'b0;
         wait_q  <= 32'h0;
      end
      else if (reset_all || !det_ok)
      begin
         state_q <= S_IDLE;
         step_q  <= 1'b0;
         wait_q  <= 32'h0;
      end
      else
      begin
         unique case (state_q)
            S_IDLE:
               if (port_output_pin)
                  state_q <= S_IDLE;
               else if (force_class && cls_ok)
                  state_q <= S_CLASS;
               else if (poll_mode || detect_cmd)
                  state_q <= S_CURR;
            S_CURR:
               if (meas_valid)
               begin
                  step_q <= !step_q;
                  if (va == pdcs_pkg::PDCS_DET_SHORT || vb == pdcs_pkg::PDCS_DET_SHORT)
                  begin
                     state_q <= S_IDLE;
                     step_q  <= 1'b0;
                  end
                  else if (step_q)
                     state_q <= both_good ? S_VOLT : S_IDLE;
               end
            S_VOLT:
               if (meas_valid)
               begin
                  step_q <= !step_q;
                  if (step_q)
                  begin
                     if (!both_good)
                        state_q <= S_IDLE;
                     else if (cls_ok)
                        state_q <= S_CLASS;
                     else
                        state_q <= S_WAIT;
                  end
               end
            S_CLASS:
               if (meas_valid)
                  state_q <= S_WAIT;
            S_WAIT:
               if (!poll_mode || auto_mode)
                  state_q <= S_IDLE;
               else if (wait_q >= WAIT_CYC - 1)
               begin
                  state_q <= S_IDLE;
                  wait_q  <= 32'h0;
               end
               else
                  wait_q <= wait_q + 32'h1;
         endcase
      end
   end

   // Status moves when a cycle ends, and clears to unknown when both channels read good at the second current step, so a host never reads half a cycle.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port_det   <= pdcs_pkg::PDCS_DET_UNKNOWN;
         chan_a_det <= pdcs_pkg::PDCS_DET_UNKNOWN;
         chan_b_det <= pdcs_pkg::PDCS_DET_UNKNOWN;
         port_class <= 3'h0;
         cycle_done <= 1'b0;
      end
      else
      begin
         cycle_done <= 1'b0;
         if (state_q == S_CURR && meas_valid && (va == pdcs_pkg::PDCS_DET_SHORT || vb == pdcs_pkg::PDCS_DET_SHORT))
         begin
            port_det   <= pdcs_pkg::PDCS_DET_SHORT;
            // A short still leaves a single signature or matching channels deferring to the port.
            chan_a_det <= (conn_single || va == vb) ? pdcs_pkg::PDCS_DET_REFER : va;
            chan_b_det <= (conn_single || va == vb) ? pdcs_pkg::PDCS_DET_REFER : vb;
            cycle_done <= 1'b1;
         end
         else if ((state_q == S_CURR || state_q == S_VOLT) && meas_valid && step_q)
         begin
            if (state_q == S_CURR && both_good)
            begin
               port_det   <= pdcs_pkg::PDCS_DET_UNKNOWN;
               chan_a_det <= pdcs_pkg::PDCS_DET_UNKNOWN;
               chan_b_det <= pdcs_pkg::PDCS_DET_UNKNOWN;
            end
            else
            begin
               cycle_done <= 1'b1;
               if (conn_invalid)
               begin
                  port_det   <= pdcs_pkg::PDCS_DET_CC_INVALID;
                  chan_a_det <= pdcs_pkg::PDCS_DET_CC_INVALID;
                  chan_b_det <= pdcs_pkg::PDCS_DET_CC_INVALID;
               end
               else if (conn_single || va == vb)
               begin
                  port_det   <= va;
                  chan_a_det <= pdcs_pkg::PDCS_DET_REFER;
                  chan_b_det <= pdcs_pkg::PDCS_DET_REFER;
               end
               else
               begin
                  port_det   <= pdcs_pkg::PDCS_DET_REFER;
                  chan_a_det <= va;
                  chan_b_det <= vb;
               end
            end
         end
         else if (state_q == S_CLASS && meas_valid)
         begin
            port_class <= class_meas;
            cycle_done <= 1'b1;
         end
      end
   end

   // The result counts as good when the port or any deferred channel reported good.
   logic det_good;
   assign det_good = (port_det == pdcs_pkg::PDCS_DET_GOOD) ||
                     (port_det == pdcs_pkg::PDCS_DET_REFER &&
                      (chan_a_det == pdcs_pkg::PDCS_DET_GOOD || chan_b_det == pdcs_pkg::PDCS_DET_GOOD));

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         port_output_pin <= 1'b0;
         startup_fault   <= 1'b0;
      end
      else if (shut || power_off_cmd || reset_all)
      begin
         port_output_pin <= 1'b0;
         startup_fault   <= 1'b0;
      end
      else
      begin
         if (force_power)
            port_output_pin <= 1'b1;
         else if (power_on_cmd && !port_output_pin)
         begin
            port_output_pin <= det_good;
            startup_fault   <= !det_good;
         end
         else if (auto_mode && state_q == S_WAIT && det_good)
            port_output_pin <= 1'b1;
      end
   end

   // Auto loads from class at each class step; host writes win at any time.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         thr <= '0;
      else if (thr_wr)
         thr <= thr_wdata;
      else if (auto_mode && state_q == S_CLASS && meas_valid)
         thr <= lut_thr;
   end

   property p_short_abort;
      @(posedge clk) disable iff (!arst_n)
      (state_q == S_CURR && meas_valid && va == pdcs_pkg::PDCS_DET_SHORT && det_ok && !reset_all)
      |=> (state_q == S_IDLE && port_det == pdcs_pkg::PDCS_DET_SHORT);
   endproperty
   a_short_abort: assert property (p_short_abort) else $error("short did not abort");

   property p_fault;
      @(posedge clk) disable iff (!arst_n)
      (power_on_cmd && !port_output_pin && !force_power && !shut && !power_off_cmd && !reset_all && !det_good)
      |=> (startup_fault && !port_output_pin);
   endproperty
   a_fault: assert property (p_fault) else $error("power-on without good result");

   property p_volt_after_curr;
      @(posedge clk) disable iff (!arst_n)
      $rose(force_voltage) |-> $past(force_current);
   endproperty
   a_volt_after_curr: assert property (p_volt_after_curr) else $error("voltage step without current step");

   property p_shut_idle;
      @(posedge clk) disable iff (!arst_n)
      shut |=> (state_q == S_IDLE && !port_output_pin);
   endproperty
   a_shut_idle: assert property (p_shut_idle) else $error("shutdown port active");

   property p_thr_wr;
      @(posedge clk) disable iff (!arst_n)
      thr_wr |=> thr == $past(thr_wdata);
   endproperty
   a_thr_wr: assert property (p_thr_wr) else $error("threshold write lost");

   property p_no_det;
      @(posedge clk) disable iff (!arst_n)
      !det_ok |=> !force_current && !force_voltage;
   endproperty
   a_no_det: assert property (p_no_det) else $error("detect while inhibited");

   property p_auto_on;
      @(posedge clk) disable iff (!arst_n)
      (auto_mode && state_q == S_WAIT && det_good && !shut && !power_off_cmd && !reset_all) |=> port_output_pin;
   endproperty
   a_auto_on: assert property (p_auto_on) else $error("auto mode did not power");

   property p_class_load;
      @(posedge clk) disable iff (!arst_n)
      (auto_mode && state_q == S_CLASS && meas_valid && !thr_wr) |=> thr == $past(lut_thr);
   endproperty
   a_class_load: assert property (p_class_load) else $error("class thresholds not loaded");
endmodule : pdcs_seq
`default_nettype wire

// *** tb/pdcs_pd_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdcs_pd_model
(
   input  wire logic                 clk,
   input  wire logic                 arst_n,
   input  wire logic                 force_current,
   input  wire logic                 force_voltage,
   input  wire logic                 classification_voltage,
   input  wire pdcs_pkg::pdcs_meas_t sig_a,
   input  wire pdcs_pkg::pdcs_meas_t sig_b,
   input  wire logic [2:0]           sig_class,
   input  wire logic [2:0]           lag,
   output logic                      meas_valid,
   output pdcs_pkg::pdcs_meas_t      meas_a,
   output pdcs_pkg::pdcs_meas_t      meas_b,
   output logic [2:0]                class_meas
);
   logic [2:0] cnt_q;
   logic       probing;
   assign probing = force_current | force_voltage | classification_voltage;
   // Readings flip every cycle while nothing is probed, so a sequencer that samples them
   // outside a probe window cannot pass by luck.
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q      <= 3'h0;
         meas_valid <= 1'b0;
         meas_a     <= '0;
         meas_b     <= '0;
         class_meas <= 3'h0;
      end
      else if (!probing)
      begin
         cnt_q      <= 3'h0;
         meas_valid <= 1'b0;
         meas_a     <= ~meas_a;
         meas_b     <= ~meas_b;
         class_meas <= ~class_meas;
      end
      else
      begin
         meas_a     <= sig_a;
         meas_b     <= sig_b;
         class_meas <= sig_class;
         meas_valid <= (cnt_q == lag) && !meas_valid;
         cnt_q      <= (meas_valid || cnt_q == lag) ? 3'h0 : cnt_q + 3'h1;
      end
   end
endmodule : pdcs_pd_model
`default_nettype wire

// *** tb/poe_port_detect_classify_seq_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module poe_port_detect_classify_seq_test;
   localparam int unsigned WAIT = 10;
   logic                 clk = 1'b0, arst_n = 1'b0, auto_strap = 1'b0, reset_all = 1'b0;
   logic [1:0]           mode = 2'h1;
   logic                 detect_en = 1'b1, class_en = 1'b0, legacy_en = 1'b0;
   logic                 force_class = 1'b0, force_power = 1'b0, detect_cmd = 1'b0;
   logic                 power_on_cmd = 1'b0, power_off_cmd = 1'b0, conn_single = 1'b1;
   logic                 conn_invalid = 1'b0, thr_wr = 1'b0;
   logic [2:0]           sig_class = 3'h0, lag = 3'h1, class_meas, port_class;
   pdcs_pkg::pdcs_thr_t  thr_wdata = '0, thr, t0;
   pdcs_pkg::pdcs_meas_t sig_a = '0, sig_b = '0, meas_a, meas_b;
   logic                 meas_valid, force_current, force_voltage, probe_second, cls_v;
   logic                 pin, fault, cycle_done, saw_fv, saw_fc, saw_cv;
   pdcs_pkg::pdcs_det_t  port_det, chan_a_det, chan_b_det, expd;
   int                   err_count = 0, total_checks = 0, seed = 28025;

   always #25 clk = ~clk;

   pdcs_seq #(.WAIT_CYC(WAIT)) i_pdcs_seq
   (
      .clk(clk), .arst_n(arst_n), .auto_strap(auto_strap), .reset_all(reset_all),
      .port_op_mode_field(mode), .detect_en(detect_en), .class_en(class_en), .legacy_en(legacy_en),
      .force_class(force_class), .force_power(force_power), .detect_cmd(detect_cmd),
      .power_on_cmd(power_on_cmd), .power_off_cmd(power_off_cmd), .meas_valid(meas_valid),
      .meas_a(meas_a), .meas_b(meas_b), .conn_single(conn_single), .conn_invalid(conn_invalid),
      .class_meas(class_meas), .thr_wr(thr_wr), .thr_wdata(thr_wdata), .force_current(force_current),
      .force_voltage(force_voltage), .probe_second(probe_second), .classification_voltage(cls_v),
      .port_output_pin(pin), .startup_fault(fault), .cycle_done(cycle_done), .port_det(port_det),
      .chan_a_det(chan_a_det), .chan_b_det(chan_b_det), .port_class(port_class), .thr(thr)
   );

   pdcs_pd_model i_pdcs_pd_model
   (
      .clk(clk), .arst_n(arst_n), .force_current(force_current), .force_voltage(force_voltage),
      .classification_voltage(cls_v), .sig_a(sig_a), .sig_b(sig_b), .sig_class(sig_class),
      .lag(lag), .meas_valid(meas_valid), .meas_a(meas_a), .meas_b(meas_b), .class_meas(class_meas)
   );

   task automatic summarize();
      if (err_count == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   function automatic int rr(input int lo, input int hi);
      return lo + int'({$random(seed)} % (hi - lo + 1));
   endfunction : rr

   // Values stay clear of the window edges, where the typical thresholds leave room to differ.
   function automatic pdcs_pkg::pdcs_meas_t mk(input int k);
      pdcs_pkg::pdcs_meas_t m;
      m.res_k = 8'(rr(18, 28));
      m.volt_mv = 16'(rr(1100, 9900));
      m.cap_nf = 16'(rr(0, 2600));
      case (k)
         1: m.res_k = 8'(rr(1, 16));
         2: m.res_k = 8'(rr(30, 49));
         3: m.res_k = 8'(rr(51, 250));
         4: m.volt_mv = 16'(rr(0, 900));
         5: m.volt_mv = 16'(rr(10100, 20000));
         6: m.cap_nf = 16'(rr(2800, 9900));
         7: m.cap_nf = 16'(rr(10100, 30000));
         default: ;
      endcase
      return m;
   endfunction : mk

   function automatic pdcs_pkg::pdcs_det_t exp_det(input pdcs_pkg::pdcs_meas_t m, input logic leg);
      if (m.volt_mv < 16'h03e8) return pdcs_pkg::PDCS_DET_SHORT;
      if (m.volt_mv > 16'h2710) return pdcs_pkg::PDCS_DET_VOLT_OUT;
      if (leg && m.cap_nf > 16'h2710) return pdcs_pkg::PDCS_DET_GOOD;
      if (m.cap_nf > 16'h0a8c) return pdcs_pkg::PDCS_DET_CAP_HIGH;
      if (m.res_k < 8'h11) return pdcs_pkg::PDCS_DET_R_LOW;
      if (m.res_k > 8'h32) return pdcs_pkg::PDCS_DET_OPEN;
      if (m.res_k > 8'h1d) return pdcs_pkg::PDCS_DET_R_HIGH;
      return pdcs_pkg::PDCS_DET_GOOD;
   endfunction : exp_det

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   task automatic wait_done();
      int n;
      n = 0;
      saw_fv = 1'b0;
      while (cycle_done !== 1'b1 && n < 2000)
      begin
         @(negedge clk);
         saw_fv |= (force_voltage === 1'b1);
         n++;
      end
      check("cycle_done", cycle_done, 1'b1);
   endtask : wait_done

   task automatic watch(input int c);
      saw_fc = 1'b0;
      saw_cv = 1'b0;
      repeat (c)
      begin
         @(negedge clk);
         saw_fc |= (force_current === 1'b1);
         saw_cv |= (cls_v === 1'b1);
      end
   endtask : watch

   task automatic run(input int ka, input int kb);
      sig_a = mk(ka);
      sig_b = (kb < 0) ? sig_a : mk(kb);
      lag = 3'(rr(1, 4));
      pulse(detect_cmd);
      wait_done();
      check("probe_second", probe_second, 1'b0);
   endtask : run

   task automatic wait_pin();
      int n;
      n = 0;
      while (pin !== 1'b1 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      check("port_output_pin", pin, 1'b1);
   endtask : wait_pin

   initial
   begin
      int n;
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      check("port_det", port_det, pdcs_pkg::PDCS_DET_UNKNOWN);
      check("chan_a_det", chan_a_det, pdcs_pkg::PDCS_DET_UNKNOWN);
      for (int i = 0; i < 9; i++)
      begin
         legacy_en = (i == 8);
         run((i > 7) ? 7 : i, -1);
         expd = exp_det(sig_a, legacy_en);
         check("port_det", port_det, expd);
         check("chan_b_det", chan_b_det, pdcs_pkg::PDCS_DET_REFER);
         if (i < 5) check("second_step", saw_fv, i == 0);
         pulse(power_on_cmd);
         @(negedge clk);
         check("port_output_pin", pin, expd == pdcs_pkg::PDCS_DET_GOOD);
         check("startup_fault", fault, expd != pdcs_pkg::PDCS_DET_GOOD);
         pulse(power_off_cmd);
      end
      legacy_en = 1'b0;
      watch(30);
      check("idle_probe", saw_fc, 1'b0);
      conn_single = 1'b0;
      run(0, 1);
      check("port_det", port_det, pdcs_pkg::PDCS_DET_REFER);
      check("chan_a_det", chan_a_det, pdcs_pkg::PDCS_DET_GOOD);
      check("chan_b_det", chan_b_det, pdcs_pkg::PDCS_DET_R_LOW);
      conn_invalid = 1'b1;
      run(0, 2);
      check("cc_invalid", (port_det === pdcs_pkg::PDCS_DET_CC_INVALID) ||
            (chan_a_det === pdcs_pkg::PDCS_DET_CC_INVALID), 1'b1);
      conn_invalid = 1'b0;
      conn_single = 1'b1;
      run(1, -1);
      force_power = 1'b1;
      pulse(power_on_cmd);
      @(negedge clk);
      check("port_output_pin", pin, 1'b1);
      pulse(power_off_cmd);
      force_power = 1'b0;
      class_en = 1'b1;
      force_class = 1'b1;
      run(3, -1);
      watch(30);
      check("class_probe", saw_cv, 1'b1);
      force_class = 1'b0;
      // Let the last forced class event drain, since a command outside idle is ignored.
      repeat (12) @(negedge clk);
      sig_class = 3'(rr(1, 4));
      run(0, -1);
      watch(30);
      check("class_probe", saw_cv, 1'b1);
      check("port_class", port_class, sig_class);
      class_en = 1'b0;
      run(0, -1);
      watch(30);
      check("class_probe", saw_cv, 1'b0);
      auto_strap = 1'b1;
      detect_en = 1'b0;
      pulse(detect_cmd);
      watch(30);
      check("det_probe", saw_fc, 1'b0);
      detect_en = 1'b1;
      mode = 2'h0;
      pulse(detect_cmd);
      watch(30);
      check("det_probe", saw_fc, 1'b0);
      mode = 2'h2;
      wait_done();
      n = 0;
      while (force_current !== 1'b1 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      check("repeat_gap", n >= WAIT && n < 500, 1'b1);
      check("port_output_pin", pin, 1'b0);
      wait_done();
      check("port_det", port_det, pdcs_pkg::PDCS_DET_GOOD);
      class_en = 1'b1;
      sig_class = 3'h0;
      // Enter auto only once a fresh cycle runs, so its class step loads the thresholds.
      n = 0;
      while (force_current !== 1'b1 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      mode = 2'h3;
      wait_pin();
      check("port_class", port_class, 3'h0);
      t0 = thr;
      thr_wdata = 24'($random(seed));
      pulse(thr_wr);
      check("thr", thr, thr_wdata);
      mode = 2'h0;
      repeat (3) @(negedge clk);
      check("port_output_pin", pin, 1'b0);
      sig_class = 3'h3;
      mode = 2'h3;
      wait_pin();
      check("thr", thr, t0);
      pulse(reset_all);
      @(negedge clk);
      check("port_output_pin", pin, 1'b0);
      summarize();
   end

   initial
   begin
      #(60000 * 50);
      err_count++;
      summarize();
   end
endmodule : poe_port_detect_classify_seq_test
`default_nettype wire
